/* File: bffs_pkg.sv */
// Shared constants and types of the two-way queue flag and mailbox block
package bffs_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int DATA_W = 36;
   localparam int QUEUE_DEPTH = 64;
   localparam int OFS_W = 6;
   localparam int NUM_PORTS = 2;
   localparam int LEFT = 0;
   localparam int RIGHT = 1;
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;
   localparam int STAT_W = 4;

   ////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses
   localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h00;
   localparam logic [AXI_ADDR_W-1:0] REG_MASK = 8'h04;
   localparam logic [AXI_ADDR_W-1:0] REG_AE_OFS = 8'h08;
   localparam logic [AXI_ADDR_W-1:0] REG_AF_OFS = 8'h0c;
   localparam logic [AXI_ADDR_W-1:0] REG_FLAGS = 8'h10;

   // Status bit positions: mail posted by port p, write refused at port p
   localparam int STAT_MAIL_LSB = 0;
   localparam int STAT_REFUSE_LSB = 2;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [STAT_W-1:0] RST_MASK = 4'h0;
   localparam logic [OFS_W-1:0] RST_AE_OFS = 6'h08;
   localparam logic [OFS_W-1:0] RST_AF_OFS = 6'h08;
   localparam logic RST_NEWMAIL_N = 1'h1;
   localparam logic RST_FULL_N = 1'h1;
   localparam logic RST_AF_N = 1'h1;
   localparam logic RST_EF_N = 1'h0;
   localparam logic RST_AE_N = 1'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic select_n;
      logic direction;
      logic enable;
      logic mailbox_select;
      logic [DATA_W-1:0] data;
   } bffs_port_ctl_s;

   typedef struct packed {
      logic clock;
      bffs_port_ctl_s ctl;
   } bffs_port_raw_s;

   typedef struct packed {
      logic [1:0] newmail_n;
      logic [1:0] full_n;
      logic [1:0] almost_full_n;
      logic [1:0] empty_n;
      logic [1:0] almost_empty_n;
   } bffs_flags_s;

   typedef enum logic [1:0] {
      BFFS_WR_IDLE = 2'h1,
      BFFS_WR_RESP = 2'h2
   } bffs_wr_state_e;

endpackage : bffs_pkg

/* File: bffs_pin_sync.sv */
// Two-flop sampler for one port's pins with rising edge detect of its clock
`timescale 1ns/1ns
module bffs_pin_sync
   import bffs_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] sampled,
   output logic rise
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic clk_d;
   } bffs_sync_s;

   bffs_sync_s sync_ff;
   bffs_sync_s nxt_sync;

   // First stage feeds only the second stage
   always_comb begin
      nxt_sync = sync_ff;
      nxt_sync.s1 = pin_in;
      nxt_sync.s2 = sync_ff.s1;
      nxt_sync.clk_d = sync_ff.s2[WIDTH-1];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_ff <= '0;
      end else begin
         sync_ff <= nxt_sync;
      end
   end

   assign sampled = sync_ff.s2;
   assign rise = sync_ff.s2[WIDTH-1] & ~sync_ff.clk_d;

endmodule : bffs_pin_sync

/* File: bffs_queue.sv */
// One direction of the two-way queue: storage, pointers and status flags
`timescale 1ns/1ns
module bffs_queue
   import bffs_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = QUEUE_DEPTH
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr_edge,
   input wire logic wr_go,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic rd_edge,
   input wire logic rd_go,
   input wire logic [OFS_W-1:0] ae_offset,
   input wire logic [OFS_W-1:0] af_offset,
   output logic [WIDTH-1:0] rd_data,
   output logic full_n,
   output logic almost_full_n,
   output logic empty_n,
   output logic almost_empty_n
);

   localparam int PW = $clog2(DEPTH) + 1;
   localparam logic [PW:0] DEPTH_X = (PW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
      logic [PW-1:0] rptr_s1;
      logic [PW-1:0] rptr_s2;
      logic [PW-1:0] wptr_s1;
      logic [PW-1:0] wptr_s2;
      logic [WIDTH-1:0] dout;
      logic full_n;
      logic af_n;
      logic ef_n;
      logic ae_n;
   } bffs_queue_s;

   bffs_queue_s q_ff;
   bffs_queue_s nxt_q;
   logic [PW:0] wcount;
   logic [PW:0] rcount;

   always_comb begin
      nxt_q = q_ff;
      // Pointers move only on a qualified port edge
      if (wr_go && q_ff.full_n) begin
         nxt_q.mem[q_ff.wptr[PW-2:0]] = wr_data;
         nxt_q.wptr = q_ff.wptr + 1'h1;
      end
      if (rd_go && q_ff.ef_n) begin
         nxt_q.dout = q_ff.mem[q_ff.rptr[PW-2:0]];
         nxt_q.rptr = q_ff.rptr + 1'h1;
      end
      // Far pointer steps through two stages on the owning port's edges,
      // so a change can slip one cycle when the edges are close
      if (wr_edge) begin
         nxt_q.rptr_s1 = q_ff.rptr;
         nxt_q.rptr_s2 = q_ff.rptr_s1;
      end
      if (rd_edge) begin
         nxt_q.wptr_s1 = q_ff.wptr;
         nxt_q.wptr_s2 = q_ff.wptr_s1;
      end
      wcount = {1'h0, nxt_q.wptr - nxt_q.rptr_s2};
      rcount = {1'h0, nxt_q.wptr_s2 - nxt_q.rptr};
      // Writer side flags rise once freed space is seen
      nxt_q.full_n = wcount != DEPTH_X;
      nxt_q.af_n = (wcount + (PW+1)'(af_offset)) < DEPTH_X;
      // Reader side flags rise once new words are seen
      nxt_q.ef_n = rcount != '0;
      nxt_q.ae_n = rcount > (PW+1)'(ae_offset);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q_ff <= '0;
         q_ff.full_n <= RST_FULL_N;
         q_ff.af_n <= RST_AF_N;
         q_ff.ef_n <= RST_EF_N;
         q_ff.ae_n <= RST_AE_N;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign rd_data = q_ff.dout;
   assign full_n = q_ff.full_n;
   assign almost_full_n = q_ff.af_n;
   assign empty_n = q_ff.ef_n;
   assign almost_empty_n = q_ff.ae_n;

endmodule : bffs_queue

/* File: bffs_top.sv */
// Two-way queue with mailboxes, port decode, flags and AXI4-Lite registers
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
module bffs_top
   import bffs_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
   input wire logic [AXI_DATA_W/8-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [AXI_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic left_port_clock,
   input wire logic left_port_select_n,
   input wire logic left_direction,
   input wire logic left_port_enable,
   input wire logic left_mailbox_select,
   input wire logic [DATA_W-1:0] left_data_in,
   output logic [DATA_W-1:0] left_data_out,
   output logic left_data_oe,
   output logic left_full_flag,
   output logic left_almost_full_flag,
   output logic left_empty_flag,
   output logic left_almost_empty_flag,
   input wire logic right_port_clock,
   input wire logic right_port_select_n,
   input wire logic right_direction,
   input wire logic right_port_enable,
   input wire logic right_mailbox_select,
   input wire logic [DATA_W-1:0] right_data_in,
   output logic [DATA_W-1:0] right_data_out,
   output logic right_data_oe,
   output logic right_full_flag,
   output logic right_almost_full_flag,
   output logic right_empty_flag,
   output logic right_almost_empty_flag,
   output logic a_to_b_newmail_flag_n,
   output logic b_to_a_newmail_flag_n,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [NUM_PORTS-1:0][DATA_W-1:0] mail;
      logic [NUM_PORTS-1:0] mail_n;
      logic [NUM_PORTS-1:0][DATA_W-1:0] dout;
      logic [NUM_PORTS-1:0] doe;
      logic [STAT_W-1:0] status;
      logic [STAT_W-1:0] mask;
      logic [OFS_W-1:0] ae_ofs;
      logic [OFS_W-1:0] af_ofs;
      logic irq;
      bffs_wr_state_e wstate;
      logic aw_held;
      logic w_held;
      logic [AXI_ADDR_W-1:0] awaddr;
      logic [AXI_DATA_W-1:0] wdata;
      logic [AXI_DATA_W/8-1:0] wstrb;
      logic [1:0] bresp;
      logic rvalid;
      logic [AXI_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } bffs_top_s;

   bffs_top_s top_ff;
   bffs_top_s nxt_top;

   bffs_port_raw_s [NUM_PORTS-1:0] raw_pins;
   bffs_port_raw_s [NUM_PORTS-1:0] pins;
   logic [NUM_PORTS-1:0] rise;
   logic [NUM_PORTS-1:0] q_wr;
   logic [NUM_PORTS-1:0] q_rd;
   logic [NUM_PORTS-1:0] m_wr;
   logic [NUM_PORTS-1:0] m_rd;
   logic [NUM_PORTS-1:0][DATA_W-1:0] q_data;
   logic [NUM_PORTS-1:0] q_full_n;
   logic [NUM_PORTS-1:0] q_af_n;
   logic [NUM_PORTS-1:0] q_ef_n;
   logic [NUM_PORTS-1:0] q_ae_n;
   bffs_flags_s flags;

   assign raw_pins[LEFT] = '{clock: left_port_clock,
      ctl: '{select_n: left_port_select_n, direction: left_direction,
             enable: left_port_enable, mailbox_select: left_mailbox_select,
             data: left_data_in}};
   assign raw_pins[RIGHT] = '{clock: right_port_clock,
      ctl: '{select_n: right_port_select_n, direction: right_direction,
             enable: right_port_enable, mailbox_select: right_mailbox_select,
             data: right_data_in}};

   ////////////////////////////////////////////////////////////////////////
   // Per port sampling, decode and queue; queue p is written by port p
   // and read by the other port
   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         bffs_pin_sync #(
            .WIDTH($bits(bffs_port_raw_s))
         ) u_pin_sync (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin_in(raw_pins[p]),
            .sampled(pins[p]),
            .rise(rise[p])
         );

         // Queue transfers need select low and enable high
         assign q_wr[p] = rise[p] & ~pins[p].ctl.select_n &
            pins[p].ctl.enable & pins[p].ctl.direction &
            ~pins[p].ctl.mailbox_select;
         assign q_rd[p] = rise[p] & ~pins[p].ctl.select_n &
            pins[p].ctl.enable & ~pins[p].ctl.direction &
            ~pins[p].ctl.mailbox_select;
         assign m_wr[p] = rise[p] & ~pins[p].ctl.select_n &
            pins[p].ctl.enable & pins[p].ctl.direction &
            pins[p].ctl.mailbox_select;
         assign m_rd[p] = rise[p] & ~pins[p].ctl.select_n &
            pins[p].ctl.enable & ~pins[p].ctl.direction &
            pins[p].ctl.mailbox_select;

         bffs_queue #(
            .WIDTH(DATA_W),
            .DEPTH(QUEUE_DEPTH)
         ) u_queue (
            .aclk(aclk),
            .aresetn(aresetn),
            .wr_edge(rise[p]),
            .wr_go(q_wr[p]),
            .wr_data(pins[p].ctl.data),
            .rd_edge(rise[NUM_PORTS-1-p]),
            .rd_go(q_rd[NUM_PORTS-1-p]),
            .ae_offset(top_ff.ae_ofs),
            .af_offset(top_ff.af_ofs),
            .rd_data(q_data[p]),
            .full_n(q_full_n[p]),
            .almost_full_n(q_af_n[p]),
            .empty_n(q_ef_n[p]),
            .almost_empty_n(q_ae_n[p])
         );
      end
   endgenerate

   assign flags = '{newmail_n: top_ff.mail_n, full_n: q_full_n,
      almost_full_n: q_af_n, empty_n: q_ef_n, almost_empty_n: q_ae_n};

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic [STAT_W-1:0] ev;
      logic [STAT_W-1:0] w1c;
      int o;
      ev = '0;
      w1c = '0;
      o = 0;
      nxt_top = top_ff;

      // Mailboxes: mail p is written by port p, read by the other port
      for (int i = 0; i < NUM_PORTS; i++) begin
         o = NUM_PORTS - 1 - i;
         // A read only frees the flag; the word stays put
         if (m_rd[o]) begin
            nxt_top.mail_n[i] = 1'h1;
         end
         // Write accepted only while the flag is high; a same-cycle read
         // that frees the flag does not admit the new word
         if (m_wr[i] && top_ff.mail_n[i]) begin
            nxt_top.mail[i] = pins[i].ctl.data;
            nxt_top.mail_n[i] = 1'h0;
            ev[STAT_MAIL_LSB+i] = 1'h1;
         end
         if ((m_wr[i] && !top_ff.mail_n[i]) || (q_wr[i] && !q_full_n[i])) begin
            ev[STAT_REFUSE_LSB+i] = 1'h1;
         end
      end

      // Data outputs: queue word unless the mailbox is selected
      for (int i = 0; i < NUM_PORTS; i++) begin
         o = NUM_PORTS - 1 - i;
         nxt_top.doe[i] = ~pins[i].ctl.select_n & ~pins[i].ctl.direction;
         nxt_top.dout[i] = pins[i].ctl.mailbox_select ? top_ff.mail[o] :
            q_data[o];
      end

      // AXI4-Lite write: address and data held in either order
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_top.aw_held = 1'h1;
         nxt_top.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_top.w_held = 1'h1;
         nxt_top.wdata = s_axi_wdata;
         nxt_top.wstrb = s_axi_wstrb;
      end
      case (top_ff.wstate)
         BFFS_WR_IDLE: begin
            if (top_ff.aw_held && top_ff.w_held) begin
               nxt_top.wstate = BFFS_WR_RESP;
               nxt_top.bresp = RESP_OKAY;
               case (top_ff.awaddr)
                  REG_STATUS: begin
                     if (top_ff.wstrb[0]) begin
                        w1c = top_ff.wdata[STAT_W-1:0];
                     end
                  end
                  REG_MASK: begin
                     if (top_ff.wstrb[0]) begin
                        nxt_top.mask = top_ff.wdata[STAT_W-1:0];
                     end
                  end
                  REG_AE_OFS: begin
                     if (top_ff.wstrb[0]) begin
                        nxt_top.ae_ofs = top_ff.wdata[OFS_W-1:0];
                     end
                  end
                  REG_AF_OFS: begin
                     if (top_ff.wstrb[0]) begin
                        nxt_top.af_ofs = top_ff.wdata[OFS_W-1:0];
                     end
                  end
                  REG_FLAGS: begin
                     nxt_top.bresp = RESP_OKAY;
                  end
                  default: begin
                     nxt_top.bresp = RESP_SLVERR;
                  end
               endcase
            end
         end
         BFFS_WR_RESP: begin
            if (s_axi_bready) begin
               nxt_top.wstate = BFFS_WR_IDLE;
               nxt_top.aw_held = 1'h0;
               nxt_top.w_held = 1'h0;
            end
         end
         default: begin
            nxt_top.wstate = BFFS_WR_IDLE;
         end
      endcase

      // Sticky events: a set in the clearing cycle survives
      nxt_top.status = (top_ff.status & ~w1c) | ev;
      nxt_top.irq = |(nxt_top.status & nxt_top.mask);

      // AXI4-Lite read: one outstanding, answer one cycle after address
      if (s_axi_arvalid && !top_ff.rvalid) begin
         nxt_top.rvalid = 1'h1;
         nxt_top.rresp = RESP_OKAY;
         case (s_axi_araddr)
            REG_STATUS: nxt_top.rdata = AXI_DATA_W'(top_ff.status);
            REG_MASK: nxt_top.rdata = AXI_DATA_W'(top_ff.mask);
            REG_AE_OFS: nxt_top.rdata = AXI_DATA_W'(top_ff.ae_ofs);
            REG_AF_OFS: nxt_top.rdata = AXI_DATA_W'(top_ff.af_ofs);
            REG_FLAGS: nxt_top.rdata = AXI_DATA_W'(flags);
            default: begin
               nxt_top.rdata = '0;
               nxt_top.rresp = RESP_SLVERR;
            end
         endcase
      end else if (top_ff.rvalid && s_axi_rready) begin
         nxt_top.rvalid = 1'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         top_ff <= '0;
         top_ff.mail_n <= {NUM_PORTS{RST_NEWMAIL_N}};
         top_ff.mask <= RST_MASK;
         top_ff.ae_ofs <= RST_AE_OFS;
         top_ff.af_ofs <= RST_AF_OFS;
         top_ff.wstate <= BFFS_WR_IDLE;
      end else begin
         top_ff <= nxt_top;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign s_axi_awready = ~top_ff.aw_held & (top_ff.wstate == BFFS_WR_IDLE);
   assign s_axi_wready = ~top_ff.w_held & (top_ff.wstate == BFFS_WR_IDLE);
   assign s_axi_bvalid = top_ff.wstate == BFFS_WR_RESP;
   assign s_axi_bresp = top_ff.bresp;
   assign s_axi_arready = ~top_ff.rvalid;
   assign s_axi_rvalid = top_ff.rvalid;
   assign s_axi_rdata = top_ff.rdata;
   assign s_axi_rresp = top_ff.rresp;

   assign left_data_out = top_ff.dout[LEFT];
   assign left_data_oe = top_ff.doe[LEFT];
   assign right_data_out = top_ff.dout[RIGHT];
   assign right_data_oe = top_ff.doe[RIGHT];

   // Writer side flags come from the queue the port writes
   assign left_full_flag = q_full_n[LEFT];
   assign left_almost_full_flag = q_af_n[LEFT];
   assign right_full_flag = q_full_n[RIGHT];
   assign right_almost_full_flag = q_af_n[RIGHT];
   // Reader side flags come from the queue the port reads
   assign left_empty_flag = q_ef_n[RIGHT];
   assign left_almost_empty_flag = q_ae_n[RIGHT];
   assign right_empty_flag = q_ef_n[LEFT];
   assign right_almost_empty_flag = q_ae_n[LEFT];

   assign a_to_b_newmail_flag_n = top_ff.mail_n[LEFT];
   assign b_to_a_newmail_flag_n = top_ff.mail_n[RIGHT];
   assign irq = top_ff.irq;

endmodule : bffs_top

/* File: bffs_port_model.sv */
// Behavioural bus master on one port of the two-way queue
`timescale 1ns/1ns
module bffs_port_model
   import bffs_pkg::*;
#(
   parameter int HALF = 262
) (
   output logic pclk,
   output logic sel_n,
   output logic dir,
   output logic en,
   output logic mb,
   output logic [DATA_W-1:0] dat
);
   initial begin
      pclk = 1'b0;
      {sel_n, dir, en, mb} = 4'h8;
      dat = '0;
   end
   // Even half period keeps port edges off the odd system clock edges
   always #(HALF) pclk = ~pclk;
   // Set up on a fall, hold through the rise until the next fall
   task automatic op(input logic d, m, input logic [DATA_W-1:0] w);
      @(negedge pclk);
      sel_n <= 1'b0;
      dir <= d;
      en <= 1'b1;
      mb <= m;
      dat <= w;
      @(negedge pclk);
      sel_n <= 1'b1;
      en <= 1'b0;
      dat <= ~w; // Released bus never keeps the last word
   endtask : op
endmodule : bffs_port_model

/* File: bffs_top_sva.sv */
// Flag timing and mail handshake checks of the two-way queue
`timescale 1ns/1ns
module bffs_top_sva
   import bffs_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic left_port_clock,
   input wire logic left_port_select_n,
   input wire logic left_direction,
   input wire logic left_port_enable,
   input wire logic left_mailbox_select,
   input wire logic right_port_clock,
   input wire logic right_port_select_n,
   input wire logic right_direction,
   input wire logic right_port_enable,
   input wire logic right_mailbox_select,
   input wire logic left_full_flag,
   input wire logic left_almost_full_flag,
   input wire logic left_empty_flag,
   input wire logic left_almost_empty_flag,
   input wire logic right_full_flag,
   input wire logic right_almost_full_flag,
   input wire logic right_empty_flag,
   input wire logic right_almost_empty_flag,
   input wire logic a_to_b_newmail_flag_n,
   input wire logic b_to_a_newmail_flag_n
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Decoded mail operation as seen by the pin samplers
   sequence s_lop(wr);
      $past(left_port_clock, 2) && !$past(left_port_select_n, 3) &&
         $past(left_direction, 3) == wr && $past(left_port_enable, 3) &&
         $past(left_mailbox_select, 3);
   endsequence
   sequence s_rop(wr);
      $past(right_port_clock, 2) && !$past(right_port_select_n, 3) &&
         $past(right_direction, 3) == wr && $past(right_port_enable, 3) &&
         $past(right_mailbox_select, 3);
   endsequence

   a_left_full_sync:
      assert property ($changed({left_full_flag, left_almost_full_flag})
         |-> $past(left_port_clock, 2)) else $error("left full off edge");
   a_left_empty_sync:
      assert property ($changed({left_empty_flag, left_almost_empty_flag})
         |-> $past(left_port_clock, 2)) else $error("left empty off edge");
   a_right_full_sync:
      assert property ($changed({right_full_flag, right_almost_full_flag})
         |-> $past(right_port_clock, 2)) else $error("right full off edge");
   a_right_empty_sync:
      assert property ($changed({right_empty_flag, right_almost_empty_flag})
         |-> $past(right_port_clock, 2)) else $error("right empty off edge");
   a_ab_mail_post:
      assert property ($fell(a_to_b_newmail_flag_n) |-> s_lop(1'b1))
         else $error("a_to_b mail set");
   a_ab_mail_take:
      assert property ($rose(a_to_b_newmail_flag_n) |-> s_rop(1'b0))
         else $error("a_to_b mail cleared");
   a_ba_mail_post:
      assert property ($fell(b_to_a_newmail_flag_n) |-> s_rop(1'b1))
         else $error("b_to_a mail set");
   a_ba_mail_take:
      assert property ($rose(b_to_a_newmail_flag_n) |-> s_lop(1'b0))
         else $error("b_to_a mail cleared");
endmodule : bffs_top_sva

bind bffs_top bffs_top_sva chk_i (.*);

/* File: bffs_top_bench.sv */
// Self-checking bench of the two-way queue block
`timescale 1ns/1ns
module bffs_top_bench import bffs_pkg::*;;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [AXI_DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq, a_to_b_newmail_flag_n, b_to_a_newmail_flag_n;
   logic left_data_oe, right_data_oe;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic left_port_clock, left_port_select_n, left_direction;
   logic left_port_enable, left_mailbox_select;
   logic right_port_clock, right_port_select_n, right_direction;
   logic right_port_enable, right_mailbox_select;
   logic [DATA_W-1:0] left_data_in, left_data_out;
   logic [DATA_W-1:0] right_data_in, right_data_out;
   logic left_full_flag, left_almost_full_flag;
   logic left_empty_flag, left_almost_empty_flag;
   logic right_full_flag, right_almost_full_flag;
   logic right_empty_flag, right_almost_empty_flag;
   int fails = 0;
   int n_checks = 0;
   logic [15:0] seed = 16'haa38;
   logic [DATA_W-1:0] q[$];

   bffs_top dut (.*);
   bffs_port_model #(.HALF(262)) lp (.pclk(left_port_clock),
      .sel_n(left_port_select_n), .dir(left_direction),
      .en(left_port_enable), .mb(left_mailbox_select), .dat(left_data_in));
   bffs_port_model #(.HALF(286)) rp (.pclk(right_port_clock),
      .sel_n(right_port_select_n), .dir(right_direction),
      .en(right_port_enable), .mb(right_mailbox_select), .dat(right_data_in));

   always #25 aclk = ~aclk;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [DATA_W-1:0] rnd();
      logic [47:0] w;
      for (int i = 0; i < 3; i++) begin
         seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
         w = {w[31:0], seed};
      end
      return w[DATA_W-1:0];
   endfunction : rnd

   function automatic logic [3:0] fl(input bit rt);
      return rt ? {right_full_flag, right_almost_full_flag, right_empty_flag,
         right_almost_empty_flag} : {left_full_flag, left_almost_full_flag,
         left_empty_flag, left_almost_empty_flag};
   endfunction : fl

   task automatic chk(input logic [63:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
      output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid);
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd

   task automatic op(input bit rt, input logic d, m,
      input logic [DATA_W-1:0] w);
      if (rt) rp.op(d, m, w);
      else lp.op(d, m, w);
      repeat (4) @(posedge aclk);
   endtask : op

   task give_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [1:0] r;
      logic [31:0] d;
      logic [3:0] f;
      logic [DATA_W-1:0] w1;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      axi_rd(REG_MASK, d, r);
      chk(d, RST_MASK, "mask reset");
      axi_rd(REG_AE_OFS, d, r);
      chk(d, RST_AE_OFS, "ae offset reset");
      axi_rd(REG_AF_OFS, d, r);
      chk(d, RST_AF_OFS, "af offset reset");
      axi_rd(REG_FLAGS, d, r);
      chk(d, {{2{RST_NEWMAIL_N}}, {2{RST_FULL_N}}, {2{RST_AF_N}},
         {2{RST_EF_N}}, {2{RST_AE_N}}}, "flags reset");
      axi_rd(8'h20, d, r);
      chk({d, r}, {32'h0, RESP_SLVERR}, "unmapped read");
      axi_wr(8'h24, 32'h1, r);
      chk(r, RESP_SLVERR, "unmapped write");
      $display("test registers done");
      for (int s = 0; s < 2; s++) begin
         q.delete();
         for (int i = 0; i < QUEUE_DEPTH; i++) begin
            w1 = rnd();
            q.push_back(w1);
            op(s, 1'b1, 1'b0, w1);
         end
         op(s, 1'b1, 1'b0, rnd());
         f = fl(s);
         chk(f[3:2], 2'b00, "writer full");
         f = fl(!s);
         chk(f[1:0], 2'b11, "reader filled");
         axi_rd(REG_STATUS, d, r);
         chk(d[STAT_REFUSE_LSB + s], 1'b1, "refused write");
         for (int i = 0; i < QUEUE_DEPTH; i++) begin
            op(!s, 1'b0, 1'b0, '0);
            chk(s ? left_data_out : right_data_out, q.pop_front(), "word");
            chk(s ? left_data_oe : right_data_oe, 1'b0, "oe off");
            if (i == 0 || i == 8) begin
               repeat (36) @(posedge aclk);
               f = fl(s);
               chk(f[3:2], {1'b1, i == 8}, "writer space");
            end
         end
         op(!s, 1'b0, 1'b0, '0);
         chk(s ? left_data_out : right_data_out, w1, "empty read");
         f = fl(!s);
         chk(f[1:0], 2'b00, "reader empty");
         $display("test queue %0d done", s);
      end
      for (int s = 0; s < 2; s++) begin
         w1 = rnd();
         op(s, 1'b1, 1'b1, w1);
         chk(s ? b_to_a_newmail_flag_n : a_to_b_newmail_flag_n, 1'b0, "post");
         op(s, 1'b1, 1'b1, rnd());
         op(!s, 1'b0, 1'b1, '0);
         chk(s ? left_data_out : right_data_out, w1, "mail word");
         chk(s ? b_to_a_newmail_flag_n : a_to_b_newmail_flag_n, 1'b1, "take");
         op(!s, 1'b0, 1'b1, '0);
         chk(s ? left_data_out : right_data_out, w1, "mail kept");
         $display("test mail %0d done", s);
      end
      axi_wr(REG_MASK, 32'h0, r);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0, "irq masked");
      for (int k = 0; k < STAT_W; k++) begin
         axi_wr(REG_MASK, 32'h1 << k, r);
         repeat (2) @(posedge aclk);
         chk(irq, 1'b1, "irq raised");
      end
      axi_wr(REG_STATUS, 32'hf, r);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0, "irq cleared");
      axi_rd(REG_STATUS, d, r);
      chk(d, 32'h0, "status cleared");
      $display("test interrupt done");
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      give_verdict();
   end
endmodule : bffs_top_bench
